// *** cmon_clock_monitor.sv ***
`timescale 1ns/10ps
//
// Contract
// - mode register byte and bit writable, reset zero
// - bit zero enables the monitor
// - enable bit sticky until external, internal or own reset
// - own reset clears enable, sets cause flag
// - monitor runs when enabled and not suspended
// - inactive from reset until stabilization ends
// - suspended in STOP and following stabilization
// - suspended while software stops main oscillator
// - suspended while sampling oscillator is stopped
// - runs only in normal operation, input oscillating
// - enable during stabilization defers until end
// - enable after stabilization starts immediately
// - resumes after STOP stabilization automatically
// - resumes after software restart and stabilization
// - internal stop ineffective when configuration forbids
// - watchdog and low voltage set own flag only; power-on clears
// - internal oscillator samples main input, resets
// - cause register clears on reset and read
module cmon_clock_monitor
	import cmon_pkg::*;
#(
	parameter int LOSS_TIMEOUT = CMON_LOSS_TIMEOUT_CYCLES,
	parameter int RST_HOLD = CMON_RST_HOLD_CYCLES
)
(
	// clock and external reset
	input wire logic ref_clk,
	input wire logic rstn,
	// monitored main oscillator input
	input wire logic mainOscInput,
	// mode register access
	input wire logic modeByteWrEn,
	input wire logic [7:0] modeByteWrData,
	input wire logic modeBitWrEn,
	input wire logic [2:0] modeBitWrIdx,
	input wire logic modeBitWrVal,
	output logic [7:0] clockMonitorMode,
	// reset cause register access
	input wire logic causeRdEn,
	output logic [7:0] causeRdData,
	// other reset sources
	input wire logic powerOnClear,
	input wire logic watchdogReset,
	input wire logic lowVoltageReset,
	input wire logic internalReset,
	// suspension conditions
	input wire logic stopMode,
	input wire logic oscStabilizing,
	input wire logic mainOscStopBit,
	input wire logic mainClockCutBit,
	input wire logic internalOscStopBit,
	input wire logic internalOscStopAllowed,
	// status and reset request
	output logic intOscHalted,
	output logic monitorActive,
	output logic clockLossReset
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (RST_HOLD < 1)
	begin : gBadHold
		$error("cmon_clock_monitor reset hold must be at least one cycle");
	end

	// below eight the synchroniser latency eats most of the window
	if (LOSS_TIMEOUT < 8)
	begin : gBadTimeout
		$error("cmon_clock_monitor loss timeout must be at least eight cycles");
	end

	if (CMON_SYNC_STAGES < 2)
	begin : gBadStages
		$error("cmon_clock_monitor needs at least two synchroniser stages");
	end

	// the register images below are fixed at one byte
	if (CMON_MODE_W != 8 || CMON_CAUSE_W != 8)
	begin : gBadWidth
		$error("cmon_clock_monitor register width must be eight bits");
	end

	if (CMON_MODE_ENABLE_BIT >= 8 || CMON_CAUSE_CLKLOSS_BIT >= 8 || CMON_CAUSE_WDOG_BIT >= 8
		|| CMON_CAUSE_LOWV_BIT >= 8)
	begin : gBadBit
		$error("cmon_clock_monitor bit position outside its register");
	end

	localparam int HW = $clog2(RST_HOLD + 1);

	// ****************************************
	// helpers
	// ****************************************
	// shared by the mode and cause paths
	function automatic logic [7:0] withBitSet(input logic [7:0] image, input int pos);
		logic [7:0] result;
		result = image;
		result[pos] = 1'b1;
		return result;
	endfunction : withBitSet

	// writes of zero never count, so software cannot clear the enable bit
	function automatic logic writeSetsEnable(input logic byteEn, input logic [7:0] byteData, input logic bitEn,
		input logic [2:0] bitIdx, input logic bitVal);
		logic byteSet;
		logic bitSet;
		byteSet = byteEn && byteData[CMON_MODE_ENABLE_BIT];
		bitSet = bitEn && bitIdx == 3'(CMON_MODE_ENABLE_BIT) && bitVal;
		return byteSet || bitSet;
	endfunction : writeSetsEnable

	// ****************************************
	// suspension
	// ****************************************
	logic suspended;
	logic runMonitor;
	logic stabPause;
	logic stopPause;
	logic swStopPause;
	logic intOscPause;

	always_comb
	begin
		intOscHalted = internalOscStopBit & internalOscStopAllowed;
		stabPause = oscStabilizing;
		stopPause = stopMode;
		swStopPause = mainOscStopBit | mainClockCutBit;
		intOscPause = intOscHalted;
		suspended = stabPause | stopPause | swStopPause | intOscPause;
	end

	// ****************************************
	// sampling of the main input
	// ****************************************
	logic edgeSeen;
	logic lossExpired;

	cmon_edge_sync #(
		.STAGES(CMON_SYNC_STAGES)
	) uEdge (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.rawIn(mainOscInput),
		.edgeSeen(edgeSeen)
	);

	cmon_loss_timer #(
		.TIMEOUT(LOSS_TIMEOUT)
	) uTimer (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(runMonitor),
		.kick(edgeSeen),
		.expired(lossExpired)
	);

	// ****************************************
	// mode register
	// ****************************************
	logic [7:0] modeQ;
	logic [7:0] modeD;
	logic lossFire;

	// only the enable bit is implemented; other bits read zero
	always_comb
	begin
		modeD = modeQ;
		if (writeSetsEnable(modeByteWrEn, modeByteWrData, modeBitWrEn, modeBitWrIdx, modeBitWrVal))
			modeD = withBitSet(modeD, CMON_MODE_ENABLE_BIT);
		// internal resets win over a write in the same cycle
		if (internalReset || lossFire)
			modeD = CMON_MODE_RESET;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			modeQ <= CMON_MODE_RESET;
		else
			modeQ <= modeD;
	end

	assign clockMonitorMode = modeQ;

	// ****************************************
	// monitor sequencer
	// ****************************************
	cmon_state_e stateQ;
	cmon_state_e stateD;
	logic [HW-1:0] holdQ;
	logic [HW-1:0] holdD;
	logic enabled;

	always_comb
	begin
		enabled = modeQ[CMON_MODE_ENABLE_BIT];
		runMonitor = (stateQ == CMON_WATCH) && enabled && !suspended && !internalReset;
		lossFire = 1'b0;
		stateD = stateQ;
		holdD = holdQ;
		case (stateQ)
			CMON_IDLE:
			begin
				// enabling mid-stabilization waits here; after it, starts next cycle
				if (enabled && !suspended && !internalReset)
					stateD = CMON_WATCH;
			end
			CMON_WATCH:
			begin
				if (!enabled || suspended || internalReset)
					stateD = CMON_IDLE;
				else if (lossExpired)
				begin
					lossFire = 1'b1;
					holdD = HW'(RST_HOLD - 1);
					stateD = CMON_FIRE;
				end
			end
			CMON_FIRE:
			begin
				// enable was cleared on entry, so idle holds once the request ends
				if (holdQ == '0)
					stateD = CMON_IDLE;
				else
					holdD = holdQ - HW'(1);
			end
			default:
			begin
				stateD = CMON_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stateQ <= CMON_IDLE;
			holdQ <= '0;
		end
		else
		begin
			stateQ <= stateD;
			holdQ <= holdD;
		end
	end

	// ****************************************
	// status outputs
	// ****************************************
	assign monitorActive = runMonitor;
	assign clockLossReset = (stateQ == CMON_FIRE);

	// ****************************************
	// reset cause register
	// ****************************************
	logic [7:0] causeQ;
	logic [7:0] causeD;
	logic [7:0] rdDataQ;
	logic [7:0] rdDataD;

	// read clears, but a source setting in the same cycle survives
	always_comb
	begin
		causeD = causeQ;
		rdDataD = rdDataQ;
		if (causeRdEn)
		begin
			rdDataD = causeQ;
			causeD = CMON_CAUSE_RESET;
		end
		if (watchdogReset)
			causeD = withBitSet(causeD, CMON_CAUSE_WDOG_BIT);
		if (lowVoltageReset)
			causeD = withBitSet(causeD, CMON_CAUSE_LOWV_BIT);
		if (lossFire)
			causeD = withBitSet(causeD, CMON_CAUSE_CLKLOSS_BIT);
		if (powerOnClear)
			causeD = CMON_CAUSE_RESET;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			causeQ <= CMON_CAUSE_RESET;
			rdDataQ <= CMON_CAUSE_RESET;
		end
		else
		begin
			causeQ <= causeD;
			rdDataQ <= rdDataD;
		end
	end

	assign causeRdData = rdDataQ;

endmodule : cmon_clock_monitor

// *** cmon_pkg.sv ***
package cmon_pkg;

	// ****************************************
	// mode register layout
	// ****************************************
	localparam int CMON_MODE_W = 8;
	localparam logic [7:0] CMON_MODE_RESET = 8'h00;
	localparam int CMON_MODE_ENABLE_BIT = 0;

	// ****************************************
	// reset cause register layout
	// ****************************************
	localparam int CMON_CAUSE_W = 8;
	localparam logic [7:0] CMON_CAUSE_RESET = 8'h00;
	localparam int CMON_CAUSE_LOWV_BIT = 0;
	localparam int CMON_CAUSE_CLKLOSS_BIT = 1;
	localparam int CMON_CAUSE_WDOG_BIT = 4;

	// ****************************************
	// timing
	// ****************************************
	localparam int CMON_SYNC_STAGES = 2;
	localparam int CMON_LOSS_TIMEOUT_CYCLES = 16;
	localparam int CMON_RST_HOLD_CYCLES = 4;
	// default stabilization select code after reset
	localparam logic [2:0] CMON_STAB_SELECT_RESET = 3'h5;

	typedef enum logic [1:0] {
		CMON_IDLE,
		CMON_WATCH,
		CMON_FIRE
	} cmon_state_e;

endpackage : cmon_pkg

// *** cmon_edge_sync.sv ***
`timescale 1ns/10ps
module cmon_edge_sync
	import cmon_pkg::*;
#(
	parameter int STAGES = CMON_SYNC_STAGES
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// sampled input
	input wire logic rawIn,
	// edge report
	output logic edgeSeen
);

	if (STAGES < 2)
	begin : gBadStages
		$error("cmon_edge_sync needs at least two stages");
	end

	logic [STAGES-1:0] syncQ;
	logic [STAGES-1:0] syncD;
	logic lastQ;
	logic lastD;
	logic edgeQ;
	logic edgeD;

	// first stage feeds only the second; edges judged past the chain
	always_comb
	begin
		syncD = {syncQ[STAGES-2:0], rawIn};
		lastD = syncQ[STAGES-1];
		edgeD = syncQ[STAGES-1] ^ lastQ;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			syncQ <= '0;
			lastQ <= 1'b0;
			edgeQ <= 1'b0;
		end
		else
		begin
			syncQ <= syncD;
			lastQ <= lastD;
			edgeQ <= edgeD;
		end
	end

	assign edgeSeen = edgeQ;

endmodule : cmon_edge_sync

// *** cmon_loss_timer.sv ***
`timescale 1ns/10ps
module cmon_loss_timer
	import cmon_pkg::*;
#(
	parameter int TIMEOUT = CMON_LOSS_TIMEOUT_CYCLES
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// control
	input wire logic run,
	input wire logic kick,
	// result
	output logic expired
);

	localparam int CW = $clog2(TIMEOUT + 1);

	if (TIMEOUT < 2)
	begin : gBadTimeout
		$error("cmon_loss_timer timeout too short");
	end

	logic [CW-1:0] countQ;
	logic [CW-1:0] countD;
	logic expiredQ;
	logic expiredD;

	// a stalled timer restarts from zero so a resume never inherits stale time
	always_comb
	begin
		countD = countQ;
		expiredD = 1'b0;
		if (!run || kick)
			countD = '0;
		else if (countQ == CW'(TIMEOUT - 1))
		begin
			countD = '0;
			expiredD = 1'b1;
		end
		else
			countD = countQ + CW'(1);
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			countQ <= '0;
			expiredQ <= 1'b0;
		end
		else
		begin
			countQ <= countD;
			expiredQ <= expiredD;
		end
	end

	assign expired = expiredQ;

endmodule : cmon_loss_timer

// *** cmon_clock_monitor_properties.sv ***
`timescale 1ns/10ps
module cmon_clock_monitor_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// mode register
	input wire logic modeByteWrEn,
	input wire logic [7:0] modeByteWrData,
	input wire logic modeBitWrEn,
	input wire logic [2:0] modeBitWrIdx,
	input wire logic modeBitWrVal,
	input wire logic [7:0] clockMonitorMode,
	// control and status
	input wire logic internalReset,
	input wire logic stopMode,
	input wire logic oscStabilizing,
	input wire logic mainOscStopBit,
	input wire logic mainClockCutBit,
	input wire logic intOscHalted,
	input wire logic monitorActive,
	input wire logic clockLossReset
);
	logic susp;
	logic setReq;
	assign susp = stopMode | oscStabilizing | mainOscStopBit | mainClockCutBit | intOscHalted;
	assign setReq = (modeByteWrEn & modeByteWrData[0]) | (modeBitWrEn & (modeBitWrIdx == 3'h0) & modeBitWrVal);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_suspend_blocks_active: assert property (susp |-> !monitorActive)
		else $error("active while suspended");
	a_active_needs_enable: assert property (monitorActive |-> clockMonitorMode[0])
		else $error("active without enable");
	a_mode_upper_zero: assert property (clockMonitorMode[7:1] == 7'h00)
		else $error("mode upper bits set");
	a_enable_sticky: assert property ($fell(clockMonitorMode[0]) |-> $past(internalReset) || clockLossReset)
		else $error("enable cleared by write");
	a_enable_set: assert property (setReq && !internalReset && !clockLossReset |=>
		clockMonitorMode[0] || clockLossReset)
		else $error("enable not set");
	a_loss_hold: assert property ($rose(clockLossReset) |-> clockLossReset[*4] ##1 !clockLossReset)
		else $error("loss reset width");
	a_loss_clears_enable: assert property ($rose(clockLossReset) |-> !clockMonitorMode[0])
		else $error("enable kept on loss");
	a_loss_stops_watch: assert property (clockLossReset |-> !monitorActive)
		else $error("active during loss reset");
	a_active_starts: assert property (clockMonitorMode[0] && !susp && !internalReset && !clockLossReset ##1
		!susp && !internalReset && !clockLossReset && clockMonitorMode[0] |-> monitorActive)
		else $error("monitor did not start");
endmodule : cmon_clock_monitor_properties
bind cmon_clock_monitor cmon_clock_monitor_properties u_props (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.modeByteWrEn(modeByteWrEn),
	.modeByteWrData(modeByteWrData),
	.modeBitWrEn(modeBitWrEn),
	.modeBitWrIdx(modeBitWrIdx),
	.modeBitWrVal(modeBitWrVal),
	.clockMonitorMode(clockMonitorMode),
	.internalReset(internalReset),
	.stopMode(stopMode),
	.oscStabilizing(oscStabilizing),
	.mainOscStopBit(mainOscStopBit),
	.mainClockCutBit(mainClockCutBit),
	.intOscHalted(intOscHalted),
	.monitorActive(monitorActive),
	.clockLossReset(clockLossReset)
);

// *** cmon_main_osc_model.sv ***
`timescale 1ns/10ps
module cmon_main_osc_model #(
	parameter int HALF_NS = 60
)
(
	// control
	input wire logic run,
	// oscillator pin
	output logic oscOut
);
	// a stopped crystal simply freezes at its last level
	// offset keeps every toggle clear of both reference clock edges
	initial
	begin
		oscOut = 1'h0;
		#5;
		forever #(HALF_NS) if (run) oscOut = ~oscOut;
	end
endmodule : cmon_main_osc_model

// *** cmon_clock_monitor_tb.sv ***
`timescale 1ns/10ps
module cmon_clock_monitor_tb;
	import cmon_pkg::*;
	logic ref_clk = 1'h0, rstn = 1'h0, oscRun = 1'h1, mainOscInput, modeBitWrVal = 1'h0;
	logic modeByteWrEn = 1'h0, modeBitWrEn = 1'h0, causeRdEn = 1'h0, powerOnClear = 1'h0;
	logic [7:0] modeByteWrData = 8'h00, clockMonitorMode, causeRdData, rv;
	logic [2:0] modeBitWrIdx = 3'h0;
	logic watchdogReset = 1'h0, lowVoltageReset = 1'h0, internalReset = 1'h0, stopMode = 1'h0;
	logic oscStabilizing = 1'h0, mainOscStopBit = 1'h0, mainClockCutBit = 1'h0, internalOscStopBit = 1'h0;
	logic internalOscStopAllowed = 1'h0, intOscHalted, monitorActive, clockLossReset;
	int nErrors = 0, nCompared = 0, cyc = 0;
	always #20 ref_clk = ~ref_clk;
	cmon_main_osc_model osc (.run(oscRun), .oscOut(mainOscInput));
	cmon_clock_monitor #(.LOSS_TIMEOUT(16), .RST_HOLD(4)) dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.mainOscInput(mainOscInput),
		.modeByteWrEn(modeByteWrEn),
		.modeByteWrData(modeByteWrData),
		.modeBitWrEn(modeBitWrEn),
		.modeBitWrIdx(modeBitWrIdx),
		.modeBitWrVal(modeBitWrVal),
		.clockMonitorMode(clockMonitorMode),
		.causeRdEn(causeRdEn),
		.causeRdData(causeRdData),
		.powerOnClear(powerOnClear),
		.watchdogReset(watchdogReset),
		.lowVoltageReset(lowVoltageReset),
		.internalReset(internalReset),
		.stopMode(stopMode),
		.oscStabilizing(oscStabilizing),
		.mainOscStopBit(mainOscStopBit),
		.mainClockCutBit(mainClockCutBit),
		.internalOscStopBit(internalOscStopBit),
		.internalOscStopAllowed(internalOscStopAllowed),
		.intOscHalted(intOscHalted),
		.monitorActive(monitorActive),
		.clockLossReset(clockLossReset)
	);
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		nCompared++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			nErrors++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wrByte(input logic [7:0] d);
		modeByteWrData = d;
		modeByteWrEn = 1'h1;
		tick(1);
		modeByteWrEn = 1'h0;
	endtask : wrByte
	task automatic wrBit(input logic [2:0] i, input logic v);
		modeBitWrIdx = i;
		modeBitWrVal = v;
		modeBitWrEn = 1'h1;
		tick(1);
		modeBitWrEn = 1'h0;
	endtask : wrBit
	task automatic rd;
		causeRdEn = 1'h1;
		tick(1);
		rv = causeRdData;
		causeRdEn = 1'h0;
		tick(1);
	endtask : rd
	task automatic reportAndStop;
		$display("compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : reportAndStop
	// ****************************************
	// scenarios
	// ****************************************
	task automatic tStart;
		oscStabilizing = 1'h1;
		wrByte(8'h00);
		wrBit(3'h1, 1'h1);
		tick(1);
		chk("mode", 8'h00, clockMonitorMode);
		wrByte(8'hff);
		tick(20);
		chk("mode", 8'h01, clockMonitorMode);
		chk("active", 8'h00, {7'h0, monitorActive});
		oscStabilizing = 1'h0;
		tick(2);
		chk("active", 8'h01, {7'h0, monitorActive});
		wrByte(8'h00);
		wrBit(3'h0, 1'h0);
		tick(1);
		chk("mode", 8'h01, clockMonitorMode);
		$display("start test done");
	endtask : tStart
	task automatic tSusp;
		internalOscStopAllowed = 1'h1;
		for (int k = 0; k < 5; k++)
		begin
			{oscStabilizing, internalOscStopBit, mainClockCutBit, mainOscStopBit, stopMode} = 5'(1 << k);
			oscRun = 1'h0;
			tick(40);
			chk("active", 8'h00, {7'h0, monitorActive});
			chk("lossrst", 8'h00, {7'h0, clockLossReset});
			chk("halted", {7'h0, k == 3}, {7'h0, intOscHalted});
			oscRun = 1'h1;
			tick(4);
			{oscStabilizing, internalOscStopBit, mainClockCutBit, mainOscStopBit, stopMode} = 5'h00;
			tick(2);
			chk("active", 8'h01, {7'h0, monitorActive});
		end
		internalOscStopAllowed = 1'h0;
		internalOscStopBit = 1'h1;
		tick(2);
		chk("active", 8'h01, {7'h0, monitorActive});
		chk("halted", 8'h00, {7'h0, intOscHalted});
		internalOscStopBit = 1'h0;
		$display("suspend test done");
	endtask : tSusp
	task automatic tLoss;
		watchdogReset = 1'h1;
		lowVoltageReset = 1'h1;
		tick(1);
		watchdogReset = 1'h0;
		lowVoltageReset = 1'h0;
		oscRun = 1'h0;
		for (int i = 0; i < 40 && clockLossReset !== 1'h1; i++)
			tick(1);
		chk("lossrst", 8'h01, {7'h0, clockLossReset});
		chk("mode", 8'h00, clockMonitorMode);
		chk("active", 8'h00, {7'h0, monitorActive});
		tick(6);
		chk("lossrst", 8'h00, {7'h0, clockLossReset});
		rd();
		chk("cause", 8'h13, rv);
		rd();
		chk("cause", 8'h00, rv);
		watchdogReset = 1'h1;
		tick(1);
		watchdogReset = 1'h0;
		powerOnClear = 1'h1;
		tick(1);
		powerOnClear = 1'h0;
		rd();
		chk("cause", 8'h00, rv);
		oscRun = 1'h1;
		wrBit(3'h0, 1'h1);
		tick(2);
		chk("active", 8'h01, {7'h0, monitorActive});
		internalReset = 1'h1;
		tick(1);
		internalReset = 1'h0;
		chk("mode", 8'h00, clockMonitorMode);
		wrByte(8'h01);
		rstn = 1'h0;
		tick(2);
		chk("mode", 8'h00, clockMonitorMode);
		rstn = 1'h1;
		tick(2);
		chk("active", 8'h00, {7'h0, monitorActive});
		$display("loss test done");
	endtask : tLoss
	// ****************************************
	// main sequence
	// ****************************************
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			nErrors++;
			reportAndStop();
		end
	end
	initial
	begin
		tick(3);
		rstn = 1'h1;
		tick(1);
		chk("mode", 8'h00, clockMonitorMode);
		rd();
		chk("cause", 8'h00, rv);
		tStart();
		tSusp();
		tLoss();
		reportAndStop();
	end
endmodule : cmon_clock_monitor_tb
